// ### rtl/rrc_pkg.sv
// rrc_pkg: constants, register map and types for the route and
// remote-command frame receiver.
// assumes: one clock domain, bytes arrive already deframed from a UART.
package rrc_pkg;
   // frame delimiter and checksum base
   localparam logic [7:0]  DELIM         = 8'h7E;
   localparam logic [7:0]  CSUM_BASE     = 8'hFF;
   // frame type of the source-route creation frame
   localparam logic [7:0]  ROUTE_TYPE    = 8'h21;
   // transmission option bits
   localparam logic [7:0]  OPT_NO_RETRY  = 8'h01;
   localparam logic [7:0]  OPT_APPLY     = 8'h02;
   localparam logic [7:0]  OPT_ENC       = 8'h20;
   localparam logic [7:0]  OPT_EXT       = 8'h40;
   // payload lost to application-layer encryption, in bytes
   localparam logic [15:0] ENC_OVERHEAD  = 16'h0004;
   // byte offsets inside a frame
   localparam logic [15:0] OFF_TYPE      = 16'h0003;
   localparam logic [15:0] OFF_D64_FIRST = 16'h0005;
   localparam logic [15:0] OFF_D64_LAST  = 16'h000C;
   localparam logic [15:0] OFF_D16_HI    = 16'h000D;
   localparam logic [15:0] OFF_D16_LO    = 16'h000E;
   localparam logic [15:0] OFF_OPT       = 16'h000F;
   localparam logic [15:0] OFF_NAME_HI   = 16'h0010;
   localparam logic [15:0] OFF_NAME_LO   = 16'h0011;
   localparam logic [15:0] OFF_PARAM     = 16'h0012;
   localparam logic [15:0] OFF_HOPCNT    = 16'h0010;
   localparam logic [15:0] OFF_HOP0      = 16'h0011;
   // retry interval, in clock cycles, normal and extended
   localparam logic [15:0] RETRY_STD_CYC = 16'h0040;
   localparam logic [15:0] RETRY_EXT_CYC = 16'h0400;
   // apb register byte addresses
   localparam logic [7:0]  REG_CTRL      = 8'h00;
   localparam logic [7:0]  REG_PAYLOAD   = 8'h04;
   localparam logic [7:0]  REG_STATUS    = 8'h08;
   localparam logic [7:0]  REG_DEST_HI   = 8'h0C;
   localparam logic [7:0]  REG_DEST_LO   = 8'h10;
   localparam logic [7:0]  REG_DEST16    = 8'h14;
   localparam logic [7:0]  REG_HOP_SEL   = 8'h18;
   localparam logic [7:0]  REG_HOP_DATA  = 8'h1C;
   // register reset values
   localparam logic [15:0] PAYLOAD_RST   = 16'h0040;
   // receive parser states
   typedef enum logic [2:0] {SC_HUNT, SC_LEN_H, SC_LEN_L, SC_BODY, SC_CSUM} rrc_scan_st_t;
endpackage : rrc_pkg

// ### rtl/rrc_frame_if.sv
// rrc_frame_if: body bytes and frame verdicts from the scanner.
// assumes: single clock, all signals registered by the scanner.
`timescale 1ns/1ps
interface rrc_frame_if;
   logic        b_vld;    // one body byte this cycle
   logic [7:0]  b_data;   // body byte
   logic [15:0] b_off;    // its offset in the frame
   logic        end_ok;   // checksum matched, pulse
   logic        end_bad;  // checksum wrong or frame cut, pulse
   modport scan (output b_vld, b_data, b_off, end_ok, end_bad);
   modport user (input b_vld, b_data, b_off, end_ok, end_bad);
endinterface : rrc_frame_if

// ### rtl/rrc_frame_scan.sv
// rrc_frame_scan: finds frames, counts length, checks the checksum.
// assumes: rx bytes come from logic on the same clock, one per strobe.
`timescale 1ns/1ps
module rrc_frame_scan
   import rrc_pkg::*;
(
   // clock and reset
   input  wire logic  clk,
   input  wire logic  rst,
   // received bytes
   input  wire logic [7:0] rx_data,
   input  wire logic  rx_valid,
   // frame stream
   rrc_frame_if.scan  fr
);
   rrc_scan_st_t st_ff;     // parser state
   logic [15:0]  len_ff;    // remaining body bytes
   logic [15:0]  off_ff;    // offset of the next byte
   logic [7:0]   sum_ff;    // running body sum
   logic         delim;     // delimiter seen now
   logic         good;      // checksum byte matches

   assign delim = rx_valid && (rx_data == DELIM);
   assign good  = (rx_data == (CSUM_BASE - sum_ff));

   ////////////////////////////////////////////////////////////////////////
   // state: a delimiter always restarts, even in mid-frame
   always_ff @(posedge clk)
   begin
      if (rst)
         st_ff <= SC_HUNT;
      else if (delim)
         st_ff <= SC_LEN_H;
      else if (rx_valid)
      begin
         case (st_ff)
            SC_LEN_H: st_ff <= SC_LEN_L;
            SC_LEN_L: st_ff <= ({len_ff[7:0], rx_data} == 16'h0000) ? SC_CSUM : SC_BODY;
            SC_BODY:  st_ff <= (len_ff == 16'h0001) ? SC_CSUM : SC_BODY;
            default:  st_ff <= SC_HUNT;                       // csum done or hunting
         endcase
      end
   end

   // length count, high byte first, then down-count of body bytes
   always_ff @(posedge clk)
   begin
      if (rst)
         len_ff <= 16'h0000;
      else if (rx_valid && !delim)
      begin
         case (st_ff)
            SC_LEN_H: len_ff <= {8'h00, rx_data};
            SC_LEN_L: len_ff <= {len_ff[7:0], rx_data};
            SC_BODY:  len_ff <= len_ff - 16'h0001;
            default:  len_ff <= len_ff;
         endcase
      end
   end

   // offset and sum; the sum covers body bytes only, from the type on
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         off_ff <= 16'h0000;
         sum_ff <= 8'h00;
      end
      else if (delim)
      begin
         off_ff <= 16'h0001;
         sum_ff <= 8'h00;
      end
      else if (rx_valid)
      begin
         off_ff <= off_ff + 16'h0001;
         if (st_ff == SC_BODY)
            sum_ff <= sum_ff + rx_data;
      end
   end

   // registered outputs; a cut frame counts as bad
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         fr.b_vld   <= 1'b0;
         fr.b_data  <= 8'h00;
         fr.b_off   <= 16'h0000;
         fr.end_ok  <= 1'b0;
         fr.end_bad <= 1'b0;
      end
      else
      begin
         fr.b_vld   <= rx_valid && !delim && (st_ff == SC_BODY);
         fr.b_data  <= rx_data;
         fr.b_off   <= off_ff;
         fr.end_ok  <= rx_valid && !delim && (st_ff == SC_CSUM) && good;
         fr.end_bad <= (rx_valid && !delim && (st_ff == SC_CSUM) && !good)
                       || (delim && (st_ff != SC_HUNT));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_resync;
      delim |=> (st_ff == SC_LEN_H);
   endproperty
   a_resync: assert property (p_resync) else $error("no resync on delimiter");
   property p_csum;
      rx_valid && !delim && (st_ff == SC_CSUM) |=> (fr.end_ok == $past(good));
   endproperty
   a_csum: assert property (p_csum) else $error("checksum verdict wrong");
endmodule : rrc_frame_scan

// ### rtl/rrc_top.sv
// rrc_top: receives source-route and remote-command frames, keeps the
// route, and presents decoded commands; apb slave for control/status.
// assumes: bytes from a same-clock uart, apb master on CORE_CLK.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
module rrc_top
   import rrc_pkg::*;
#(
   parameter int          MAX_HOPS    = 16,       // route entries kept
   parameter int          PARAM_BYTES = 4,        // parameter bytes kept
   parameter logic [7:0]  REMOTE_TYPE = 8'h00,    // remote command frame type
   parameter logic [15:0] COMMIT_NAME = 16'h4143  // name of the commit command
)
(
   // clock and reset
   input  wire logic        CORE_CLK,
   input  wire logic        RST,
   // uart byte stream
   input  wire logic [7:0]  RX_DATA,
   input  wire logic        RX_VALID,
   // apb slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // decoded remote command
   output logic             CMD_VALID,
   output logic [15:0]      CMD_NAME,
   output logic             CMD_IS_WRITE,
   output logic [8*PARAM_BYTES-1:0] CMD_PARAM,
   output logic             CMD_NO_RETRY,
   output logic             CMD_ENC,
   output logic [15:0]      CMD_RETRY_CYC,
   output logic [15:0]      CMD_USABLE_PAYLOAD,
   // settings taking effect
   output logic             APPLY_STROBE,
   output logic [15:0]      APPLY_NAME,
   output logic [8*PARAM_BYTES-1:0] APPLY_PARAM,
   // stored route
   output logic             ROUTE_VALID
);
   localparam int HW = $clog2(MAX_HOPS);
   localparam int PW = 8 * PARAM_BYTES;

   rrc_frame_if fr ();
   rrc_frame_scan u_scan (
      .clk      (CORE_CLK),
      .rst      (RST),
      .rx_data  (RX_DATA),
      .rx_valid (RX_VALID),
      .fr       (fr.scan)
   );

   ////////////////////////////////////////////////////////////////////////
   // shadow fields of the frame in flight; used only on a good end
   logic [7:0]  type_ff;        // frame type
   logic [7:0]  sh_opt_ff;      // option byte
   logic [15:0] sh_name_ff;     // command name
   logic [PW-1:0] sh_param_ff;  // parameter bytes, last in low bits
   logic [7:0]  sh_pcnt_ff;     // parameter byte count
   logic [63:0] sh_d64_ff;      // 64-bit destination
   logic [15:0] sh_d16_ff;      // 16-bit destination
   logic [7:0]  sh_hops_ff;     // hop count
   logic        hop_err_ff;     // more hops than storage
   logic [15:0] hop_rel;        // offset past the first hop byte
   logic [15:0] hop_mem [2*MAX_HOPS];  // two banks, one live
   logic        bank_ff;        // live bank
   logic [63:0] dest64_ff;      // stored destination
   logic [15:0] dest16_ff;      // stored network address
   logic [7:0]  hop_cnt_ff;     // stored hop count
   logic        is_route;
   logic        is_cmd;
   logic [7:0]  opt_for_cmd;    // option byte seen at end

   assign hop_rel  = fr.b_off - OFF_HOP0;
   assign is_route = (type_ff == ROUTE_TYPE);
   assign is_cmd   = (type_ff == REMOTE_TYPE);
   assign opt_for_cmd = sh_opt_ff;

   // capture fields by offset; end of frame, good or bad, clears counts
   always_ff @(posedge CORE_CLK)
   begin
      if (RST || fr.end_ok || fr.end_bad)
      begin
         type_ff    <= 8'h00;
         sh_pcnt_ff <= 8'h00;
         hop_err_ff <= 1'b0;
         sh_opt_ff  <= 8'h00;
         sh_name_ff <= 16'h0000;
         sh_param_ff <= '0;
         sh_d64_ff  <= 64'h0;
         sh_d16_ff  <= 16'h0000;
         sh_hops_ff <= 8'h00;
      end
      else if (fr.b_vld)
      begin
         if (fr.b_off == OFF_TYPE)
            type_ff <= fr.b_data;
         if (fr.b_off >= OFF_D64_FIRST && fr.b_off <= OFF_D64_LAST)
            sh_d64_ff <= {sh_d64_ff[55:0], fr.b_data};
         if (fr.b_off == OFF_D16_HI)
            sh_d16_ff[15:8] <= fr.b_data;
         if (fr.b_off == OFF_D16_LO)
            sh_d16_ff[7:0] <= fr.b_data;
         if (fr.b_off == OFF_OPT)
            sh_opt_ff <= fr.b_data;
         if (fr.b_off == OFF_NAME_HI)
            sh_name_ff[15:8] <= fr.b_data;
         if (fr.b_off == OFF_NAME_LO)
            sh_name_ff[7:0] <= fr.b_data;
         if (fr.b_off == OFF_HOPCNT)
            sh_hops_ff <= fr.b_data;
         if (is_cmd && fr.b_off >= OFF_PARAM)
         begin
            sh_param_ff <= {sh_param_ff[PW-9:0], fr.b_data};
            sh_pcnt_ff  <= sh_pcnt_ff + 8'h01;
         end
         if (is_route && fr.b_off >= OFF_HOP0 && hop_rel[15:1] >= 15'(MAX_HOPS))
            hop_err_ff <= 1'b1;
      end
   end

   // hop list goes to the idle bank; entry 0 is next to the destination
   always_ff @(posedge CORE_CLK)
   begin
      if (fr.b_vld && is_route && fr.b_off >= OFF_HOP0
          && hop_rel[15:1] < 15'(MAX_HOPS))
      begin
         if (!hop_rel[0])
            hop_mem[{~bank_ff, hop_rel[HW:1]}][15:8] <= fr.b_data;
         else
            hop_mem[{~bank_ff, hop_rel[HW:1]}][7:0] <= fr.b_data;
      end
   end

   // commit a route only on a good checksum and sane hop count
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         bank_ff     <= 1'b0;
         ROUTE_VALID <= 1'b0;
         dest64_ff   <= 64'h0;
         dest16_ff   <= 16'h0000;
         hop_cnt_ff  <= 8'h00;
      end
      else if (fr.end_ok && is_route && !hop_err_ff
               && sh_hops_ff <= 8'(MAX_HOPS))
      begin
         bank_ff     <= ~bank_ff;
         ROUTE_VALID <= 1'b1;
         dest64_ff   <= sh_d64_ff;
         dest16_ff   <= sh_d16_ff;
         hop_cnt_ff  <= sh_hops_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control registers written by software
   logic        enc_en_ff;      // encryption_enable_setting
   logic [15:0] max_pay_ff;     // max_payload_size_report
   logic [HW-1:0] hop_sel_ff;   // hop entry shown on read
   logic        acc_wr;

   assign acc_wr = PSEL && PENABLE && PWRITE;

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         enc_en_ff  <= 1'b0;
         max_pay_ff <= PAYLOAD_RST;
         hop_sel_ff <= '0;
      end
      else if (acc_wr)
      begin
         case (PADDR)
            REG_CTRL:    enc_en_ff  <= PWDATA[0];
            REG_PAYLOAD: max_pay_ff <= PWDATA[15:0];
            REG_HOP_SEL: hop_sel_ff <= PWDATA[HW-1:0];
            default:     enc_en_ff  <= enc_en_ff;              // read-only or unmapped
         endcase
      end
   end

   // decoded command; set only by a good frame
   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         CMD_VALID          <= 1'b0;
         CMD_NAME           <= 16'h0000;
         CMD_IS_WRITE       <= 1'b0;
         CMD_PARAM          <= '0;
         CMD_NO_RETRY       <= 1'b0;
         CMD_ENC            <= 1'b0;
         CMD_RETRY_CYC      <= RETRY_STD_CYC;
         CMD_USABLE_PAYLOAD <= PAYLOAD_RST;
      end
      else
      begin
         CMD_VALID <= fr.end_ok && is_cmd;
         if (fr.end_ok && is_cmd)
         begin
            CMD_NAME     <= sh_name_ff;
            CMD_IS_WRITE <= (sh_pcnt_ff != 8'h00);
            CMD_PARAM    <= sh_param_ff;
            CMD_NO_RETRY <= |(opt_for_cmd & OPT_NO_RETRY);
            // encryption honoured only when enabled; it costs payload
            CMD_ENC <= |(opt_for_cmd & OPT_ENC) && enc_en_ff;
            CMD_USABLE_PAYLOAD <= (|(opt_for_cmd & OPT_ENC) && enc_en_ff)
                                  ? max_pay_ff - ENC_OVERHEAD : max_pay_ff;
            CMD_RETRY_CYC <= |(opt_for_cmd & OPT_EXT) ? RETRY_EXT_CYC
                                                       : RETRY_STD_CYC;
         end
      end
   end

   // pending settings: immediate with apply, else wait for commit
   logic          pend_ff;      // a setting waits
   logic [15:0]   pend_name_ff;
   logic [PW-1:0] pend_param_ff;
   logic          cmd_end;
   logic          cmd_wr;

   assign cmd_end = fr.end_ok && is_cmd;
   assign cmd_wr  = cmd_end && (sh_pcnt_ff != 8'h00) && (sh_name_ff != COMMIT_NAME);

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         pend_ff       <= 1'b0;
         pend_name_ff  <= 16'h0000;
         pend_param_ff <= '0;
         APPLY_STROBE  <= 1'b0;
         APPLY_NAME    <= 16'h0000;
         APPLY_PARAM   <= '0;
      end
      else
      begin
         APPLY_STROBE <= 1'b0;
         if (cmd_wr && |(opt_for_cmd & OPT_APPLY))
         begin
            APPLY_STROBE <= 1'b1;
            APPLY_NAME   <= sh_name_ff;
            APPLY_PARAM  <= sh_param_ff;
         end
         else if (cmd_wr)
         begin
            pend_ff       <= 1'b1;
            pend_name_ff  <= sh_name_ff;
            pend_param_ff <= sh_param_ff;
         end
         else if (cmd_end && sh_name_ff == COMMIT_NAME && pend_ff)
         begin
            pend_ff      <= 1'b0;
            APPLY_STROBE <= 1'b1;
            APPLY_NAME   <= pend_name_ff;
            APPLY_PARAM  <= pend_param_ff;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb read: data latched in setup, shown in the zero-wait access
   logic [31:0] nxt_rdata;
   logic        nxt_err;

   always_comb
   begin
      nxt_err = 1'b0;
      case (PADDR)
         REG_CTRL:     nxt_rdata = {31'h0, enc_en_ff};
         REG_PAYLOAD:  nxt_rdata = {16'h0, max_pay_ff};
         REG_STATUS:   nxt_rdata = {16'h0, hop_cnt_ff, 6'h0, pend_ff, ROUTE_VALID};
         REG_DEST_HI:  nxt_rdata = dest64_ff[63:32];
         REG_DEST_LO:  nxt_rdata = dest64_ff[31:0];
         REG_DEST16:   nxt_rdata = {16'h0, dest16_ff};
         REG_HOP_SEL:  nxt_rdata = 32'(hop_sel_ff);
         REG_HOP_DATA: nxt_rdata = {16'h0, hop_mem[{bank_ff, hop_sel_ff}]};
         default:
         begin
            nxt_rdata = 32'h0;
            nxt_err   = 1'b1;                                  // unmapped
         end
      endcase
   end

   always_ff @(posedge CORE_CLK)
   begin
      if (RST)
      begin
         PRDATA  <= 32'h0;
         PSLVERR <= 1'b0;
      end
      else if (PSEL && !PENABLE)
      begin
         PRDATA  <= PWRITE ? 32'h0 : nxt_rdata;
         PSLVERR <= nxt_err;
      end
   end

   assign PREADY = 1'b1;

   ////////////////////////////////////////////////////////////////////////
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   sequence s_route_end;
      fr.end_ok && is_route && !hop_err_ff && sh_hops_ff <= 8'(MAX_HOPS);
   endsequence
   property p_route;
      s_route_end |=> ROUTE_VALID && dest64_ff == $past(sh_d64_ff)
                     && hop_cnt_ff == $past(sh_hops_ff);
   endproperty
   a_route: assert property (p_route) else $error("route not stored");
   property p_discard;
      fr.end_bad |=> $stable(dest64_ff) && $stable(bank_ff) && !CMD_VALID;
   endproperty
   a_discard: assert property (p_discard) else $error("bad frame acted on");
   property p_wr;
      CMD_VALID |-> CMD_IS_WRITE == ($past(sh_pcnt_ff) != 8'h00);
   endproperty
   a_wr: assert property (p_wr) else $error("read/write decode wrong");
   sequence s_held;
      cmd_wr && !(|(opt_for_cmd & OPT_APPLY));
   endsequence
   property p_hold;
      s_held |=> pend_ff && !APPLY_STROBE;
   endproperty
   a_hold: assert property (p_hold) else $error("setting not held");
   property p_now;
      cmd_wr && |(opt_for_cmd & OPT_APPLY) |=> APPLY_STROBE && APPLY_NAME == $past(sh_name_ff);
   endproperty
   a_now: assert property (p_now) else $error("apply not immediate");
   property p_pay;
      CMD_VALID |-> CMD_USABLE_PAYLOAD == (CMD_ENC ? $past(max_pay_ff) - ENC_OVERHEAD
                                                   : $past(max_pay_ff));
   endproperty
   a_pay: assert property (p_pay) else $error("usable payload wrong");
   property p_ext;
      cmd_end |=> CMD_RETRY_CYC == (|($past(opt_for_cmd) & OPT_EXT) ? RETRY_EXT_CYC
                                                                  : RETRY_STD_CYC);
   endproperty
   a_ext: assert property (p_ext) else $error("retry interval wrong");
endmodule : rrc_top

// ### test/rrc_host_model.sv
// rrc_host_model: host controller that frames a body and sends its bytes.
// assumes: shares the core clock; the bench fills body, then calls send.
`timescale 1ns/1ps
module rrc_host_model
(
   // clock
   input  wire logic  clk,
   // byte stream toward the module
   output logic [7:0] rx_data,
   output logic       rx_valid
);
   logic [7:0] body[$]; // frame body, type byte first

   initial
   begin
      rx_data  = 8'h00;
      rx_valid = 1'b0;
   end

   // one byte per edge, strobe held between bytes of a frame
   task automatic put(input logic [7:0] b);
      @(posedge clk);
      rx_data  <= b;
      rx_valid <= 1'b1;
   endtask : put

   // whole frame; bad flips the checksum low bit to force a refusal
   task automatic send(input logic bad);
      logic [7:0]  sum;
      logic [15:0] len;
      sum = 8'h00;
      len = 16'(body.size());
      put(8'h7E);
      put(len[15:8]);
      put(len[7:0]);
      foreach (body[i])
      begin
         put(body[i]);
         sum = sum + body[i];
      end
      put((8'hFF - sum) ^ {7'h00, bad});
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_data  <= ~rx_data; // idle data is junk, never the last byte
      body.delete();
   endtask : send
endmodule : rrc_host_model

// ### test/testbench.sv
// testbench: remote command rows, then route, refusal and resync cases.
// assumes: rrc_top with the host model on its byte stream, apb from here.
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin errors++; $display("Error %s exp %0h got %0h", n, e, a); end end
module testbench;
   import rrc_pkg::*;
   typedef struct {logic ee; logic [7:0] opt; int np; logic nr; logic en;
                   logic [15:0] cyc; logic [15:0] pay; logic ap;} rrc_row_t;
   // name of the commit_pending_settings_command, handed to the design as well
   localparam logic [15:0] COMMIT_CMD = 16'h4143;
   logic        clk, rst, psel, penable, pwrite, pready, pslverr, cmd_valid, is_wr;
   logic        no_retry, enc, apply, route_valid, rx_valid;
   logic [7:0]  paddr, rx_data;
   logic [15:0] name, cyc, pay, apply_name;
   logic [31:0] pwdata, prdata, param, apply_param, rd;
   int          errors, n_checks;
   rrc_row_t    rows[6] = '{
      '{1'b1, 8'h01, 0, 1'b1, 1'b0, 16'h0040, 16'h0040, 1'b0},
      '{1'b1, 8'h02, 1, 1'b0, 1'b0, 16'h0040, 16'h0040, 1'b1},
      '{1'b1, 8'h20, 0, 1'b0, 1'b1, 16'h0040, 16'h003C, 1'b0},
      '{1'b0, 8'h20, 0, 1'b0, 1'b0, 16'h0040, 16'h0040, 1'b0},
      '{1'b1, 8'h62, 1, 1'b0, 1'b1, 16'h0400, 16'h003C, 1'b1},
      '{1'b1, 8'h40, 2, 1'b0, 1'b0, 16'h0400, 16'h0040, 1'b0}};
   logic [7:0]  route[20] = '{8'h21, 8'h00, 8'h00, 8'h13, 8'hA2, 8'h00, 8'h40, 8'h40,
      8'h11, 8'h22, 8'h33, 8'h44, 8'h00, 8'h03, 8'hEE, 8'hFF, 8'hCC, 8'hDD, 8'hAA, 8'hBB};

   rrc_top #(.REMOTE_TYPE(8'h17), .COMMIT_NAME(COMMIT_CMD)) u_dut (.CORE_CLK(clk),
      .RST(rst), .RX_DATA(rx_data),
      .RX_VALID(rx_valid), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .CMD_VALID(cmd_valid), .CMD_NAME(name), .CMD_IS_WRITE(is_wr), .CMD_PARAM(param),
      .CMD_NO_RETRY(no_retry), .CMD_ENC(enc), .CMD_RETRY_CYC(cyc),
      .CMD_USABLE_PAYLOAD(pay), .APPLY_STROBE(apply), .APPLY_NAME(apply_name),
      .APPLY_PARAM(apply_param), .ROUTE_VALID(route_valid));
   rrc_host_model u_host (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid));

   ////////////////////////////////////////////////////////////////////////////////
   // apb master: setup, access until pready, release after that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // remote command frame: type, id, addresses, option, name, params
   task automatic remote(input logic [7:0] opt, input int np, input logic [15:0] nm);
      u_host.body.push_back(8'h17);
      for (int i = 4; i < 13; i++)
         u_host.body.push_back(8'h00);
      u_host.body.push_back(8'hFF);
      u_host.body.push_back(8'hFE);
      u_host.body.push_back(opt);
      u_host.body.push_back(nm[15:8]);
      u_host.body.push_back(nm[7:0]);
      for (int i = 0; i < np; i++)
         u_host.body.push_back(8'(i + 1));
      u_host.send(1'b0);
   endtask : remote
   // bounded wait at the falling edge for a pulse or a level
   task automatic wait_for(input logic rte);
      int k;
      k = 0;
      @(negedge clk);
      while ((rte ? route_valid : cmd_valid) !== 1'b1 && k < 60)
      begin
         @(negedge clk);
         k++;
      end
   endtask : wait_for
   task automatic summarize;
      if (errors == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : summarize

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // watchdog, well past the few hundred cycles the run needs
   initial
   begin
      repeat (20000) @(posedge clk);
      errors++;
      summarize();
   end
   initial
   begin
      {psel, penable, pwrite, paddr, pwdata, errors, n_checks} = '0;
      rst = 1'b1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      apb(1'b0, REG_PAYLOAD, 32'h0);
      `CHK("payload_rst", 32'h00000040, rd)
      apb(1'b0, 8'h20, 32'h0);
      `CHK("unmapped_err", 1'b1, pslverr)
      foreach (rows[i])
      begin
         apb(1'b1, REG_CTRL, {31'h0, rows[i].ee});
         remote(rows[i].opt, rows[i].np, 16'h4248);
         wait_for(1'b0);
         `CHK("cmd_valid", 1'b1, cmd_valid)
         `CHK("name", 16'h4248, name)
         `CHK("no_retry", rows[i].nr, no_retry)
         `CHK("enc", rows[i].en, enc)
         `CHK("usable", rows[i].pay, pay)
         `CHK("retry_cyc", rows[i].cyc, cyc)
         `CHK("is_write", rows[i].np != 0, is_wr)
         `CHK("apply", rows[i].ap, apply)
      end
      `CHK("param", 8'h02, param[7:0])
      apb(1'b0, REG_STATUS, 32'h0);
      `CHK("pending", 1'b1, rd[1])
      remote(8'h00, 0, COMMIT_CMD);
      wait_for(1'b0);
      `CHK("commit_apply", 1'b1, apply)
      `CHK("commit_name", 16'h4248, apply_name)
      `CHK("commit_param", 32'h00000102, apply_param)
      // a software-set payload report must carry into the encrypted payload
      apb(1'b1, REG_PAYLOAD, 32'h00000050);
      apb(1'b0, REG_PAYLOAD, 32'h0);
      `CHK("payload_wr", 32'h00000050, rd)
      remote(8'h20, 0, 16'h4248);
      wait_for(1'b0);
      `CHK("usable_wr", 16'h004C, pay)
      `CHK("enc_wr", 1'b1, enc)
      foreach (route[i])
         u_host.body.push_back(route[i]);
      u_host.send(1'b1);
      repeat (10) @(negedge clk);
      `CHK("route_bad", 1'b0, route_valid)
      u_host.put(8'h7E);
      u_host.put(8'h00);
      u_host.put(8'h14);
      foreach (route[i])
         u_host.body.push_back(route[i]);
      u_host.send(1'b0);
      wait_for(1'b1);
      `CHK("route_valid", 1'b1, route_valid)
      apb(1'b0, REG_STATUS, 32'h0);
      `CHK("hops", 8'h03, rd[15:8])
      apb(1'b0, REG_DEST_HI, 32'h0);
      `CHK("d64_hi", 32'h0013A200, rd)
      apb(1'b0, REG_DEST_LO, 32'h0);
      `CHK("d64_lo", 32'h40401122, rd)
      apb(1'b0, REG_DEST16, 32'h0);
      `CHK("d16", 16'h3344, rd[15:0])
      apb(1'b1, REG_HOP_SEL, 32'h2);
      apb(1'b0, REG_HOP_DATA, 32'h0);
      `CHK("hop2", 16'hAABB, rd[15:0])
      // reset in mid-run drops the route and restores the defaults
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      `CHK("rst_route", 1'b0, route_valid)
      `CHK("rst_cyc", RETRY_STD_CYC, cyc)
      `CHK("rst_usable", PAYLOAD_RST, pay)
      apb(1'b0, REG_PAYLOAD, 32'h0);
      `CHK("rst_payload", 32'h00000040, rd)
      apb(1'b0, REG_STATUS, 32'h0);
      `CHK("rst_status", 32'h00000000, rd)
      summarize();
   end
endmodule : testbench
